/* File: verilog/ethst_consts.svh */
// offsets, frame limits and timing counts of the statistics counter bank
`ifndef ETHST_CONSTS_SVH
`define ETHST_CONSTS_SVH

`define ETHST_ADDR_W 16
`define ETHST_LEN_W 16

`define ETHST_OFF_BCAST_RX 16'h4078
`define ETHST_OFF_MCAST_RX 16'h407C
`define ETHST_OFF_GOOD_TX_FRAME 16'h4080
`define ETHST_OFF_GOOD_RX_OCT_LO 16'h4088
`define ETHST_OFF_GOOD_RX_OCT_HI 16'h408C
`define ETHST_OFF_GOOD_TX_OCT_LO 16'h4090
`define ETHST_OFF_GOOD_TX_OCT_HI 16'h4094
`define ETHST_OFF_NO_HOST_BUF 16'h40A0
`define ETHST_OFF_SHORT_GOOD_CRC 16'h40A4
`define ETHST_OFF_SHORT_BAD_CRC 16'h40A8
`define ETHST_OFF_LONG_FRAME 16'h40AC
`define ETHST_OFF_LONG_BAD_CRC 16'h40B0
`define ETHST_OFF_MGMT_RX 16'h40B4
`define ETHST_OFF_MGMT_DROP 16'h40B8
`define ETHST_OFF_MGMT_TX 16'h40BC

`define ETHST_RESET_VAL 32'h0000_0000
`define ETHST_MIN_FRAME 16'h0040
`define ETHST_MAX_STD_FRAME 16'h05F2
`define ETHST_MAX_LONG_FRAME 16'h4000
`define ETHST_NUM_CNT32 11
`define ETHST_LIM_32 64'h0000_0000_FFFF_FFFF
`define ETHST_LIM_16 64'h0000_0000_0000_FFFF
`define ETHST_LIM_64 64'hFFFF_FFFF_FFFF_FFFF

`define ETHST_CLK_PERIOD_NS 40
`define ETHST_EVENT_MAX_NS 1000
`define ETHST_EVENT_MAX_CYC (`ETHST_EVENT_MAX_NS / `ETHST_CLK_PERIOD_NS)

`endif

/* File: verilog/ethst_pkg.sv */
// types shared by the statistics counter bank
package ethst_pkg;

  // ids below 11 double as the index of the 32-bit counter
  typedef enum logic [3:0] {
    ETHST_ID_BCAST = 4'h0,
    ETHST_ID_MCAST = 4'h1,
    ETHST_ID_GTX = 4'h2,
    ETHST_ID_NOBUF = 4'h3,
    ETHST_ID_SGOOD = 4'h4,
    ETHST_ID_SBAD = 4'h5,
    ETHST_ID_LONG = 4'h6,
    ETHST_ID_LBAD = 4'h7,
    ETHST_ID_MRX = 4'h8,
    ETHST_ID_MDROP = 4'h9,
    ETHST_ID_MTX = 4'hA,
    ETHST_ID_RXLO = 4'hB,
    ETHST_ID_RXHI = 4'hC,
    ETHST_ID_TXLO = 4'hD,
    ETHST_ID_TXHI = 4'hE,
    ETHST_ID_NONE = 4'hF
  } ethst_reg_id_type;

  typedef struct packed {
    logic bcast;
    logic mcast;
    logic nobuf;
    logic short_good;
    logic short_bad;
    logic long_any;
    logic long_bad;
    logic oct_vld;
    logic [15:0] oct_len;
  } ethst_rx_ev_type;

endpackage : ethst_pkg

/* File: verilog/ethst_rx_class.sv */
// receive frame classifier: turns one frame-end report into counter events
`timescale 1ns/10ps
`include "ethst_consts.svh"
module ethst_rx_class (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic rx_frame_done,
  input wire logic [`ETHST_LEN_W-1:0] rx_frame_len,
  input wire logic rx_crc_ok,
  input wire logic rx_addr_pass,
  input wire logic rx_is_bcast,
  input wire logic rx_is_mcast,
  input wire logic rx_is_flow_ctrl,
  input wire logic rx_fifo_missed,
  input wire logic rx_desc_empty,
  input wire logic rx_enable,
  input wire logic long_frame_enable,
  output ethst_pkg::ethst_rx_ev_type rx_ev
);
  import ethst_pkg::*;

  typedef struct packed {
    ethst_rx_ev_type ev;
  } ethst_rx_state_type;

  ethst_rx_state_type st_reg;
  ethst_rx_state_type st_next;
  logic take;
  logic good;
  logic is_short;
  logic is_long;

  always_comb begin
    st_next = st_reg;
    // every counter here stays put while reception is off
    take = rx_frame_done & rx_enable & rx_addr_pass; // RULE_15
    good = take & rx_crc_ok & ~rx_fifo_missed;
    is_short = rx_frame_len < `ETHST_MIN_FRAME;
    // lengths past 16 bits must be clamped by the mac, not wrapped
    is_long = long_frame_enable ? (rx_frame_len > `ETHST_MAX_LONG_FRAME) :
      (rx_frame_len > `ETHST_MAX_STD_FRAME); // RULE_13
    st_next.ev.bcast = good & rx_is_bcast; // RULE_01
    st_next.ev.mcast = good & rx_is_mcast & ~rx_is_flow_ctrl; // RULE_02
    st_next.ev.nobuf = take & rx_desc_empty & ~rx_is_flow_ctrl; // RULE_10
    st_next.ev.short_good = take & is_short & rx_crc_ok; // RULE_11
    st_next.ev.short_bad = take & is_short & ~rx_crc_ok; // RULE_12
    st_next.ev.long_any = take & is_long; // RULE_14
    st_next.ev.long_bad = take & is_long & ~rx_crc_ok; // RULE_14
    st_next.ev.oct_vld = good & ~rx_is_flow_ctrl; // RULE_05
    st_next.ev.oct_len = rx_frame_len;
    if (srst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  assign rx_ev = st_reg.ev;

endmodule : ethst_rx_class

/* File: verilog/ethst_counters.sv */
// ethernet statistics counter bank behind an apb slave
// What this block does
// RULE_01: count good filtered broadcasts, not missed ones
// RULE_02: count good filtered multicasts, no pause, no missed
// RULE_03: count good tx frames of 64+ bytes
// RULE_04: secured and clear tx traffic count alike
// RULE_05: 64-bit good rx octets, no pause frames
// RULE_06: low-half read snapshots the upper half
// RULE_07: software reads low half, then high half
// RULE_08: tx octet counter sticks at all ones
// RULE_09: tx octets of good 64+ byte frames only
// RULE_10: count frames arriving with no host buffer
// RULE_11: short filtered frame with good crc counts
// RULE_12: short filtered frame with bad crc counts
// RULE_13: oversize limit 1522, or 16384 with long frames
// RULE_14: oversize counts; oversize with bad crc too
// RULE_15: receive error counters hold while rx disabled
// RULE_16: count management-filtered or redirected good frames; errored frames also count while the fifo is full
// RULE_17: 16-bit count of management frames dropped full
// RULE_18: 16-bit count of management-path transmitted frames
// RULE_19: counters clear on read and saturate
// RULE_20: events reach counters within one microsecond
// RULE_21: high read alone returns last snapshot, untouched
// RULE_22: increment in clearing cycle is kept
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "ethst_consts.svh"
module ethst_counters (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ETHST_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_frame_done,
  input wire logic [`ETHST_LEN_W-1:0] rx_frame_len,
  input wire logic rx_crc_ok,
  input wire logic rx_addr_pass,
  input wire logic rx_is_bcast,
  input wire logic rx_is_mcast,
  input wire logic rx_is_flow_ctrl,
  input wire logic rx_fifo_missed,
  input wire logic rx_desc_empty,
  input wire logic rx_enable,
  input wire logic long_frame_enable,
  input wire logic tx_frame_done,
  input wire logic [`ETHST_LEN_W-1:0] tx_frame_len,
  input wire logic tx_ok,
  input wire logic tx_is_flow_ctrl,
  input wire logic tx_enable,
  input wire logic mgmt_rx_done,
  input wire logic mgmt_filter_pass,
  input wire logic mgmt_cb_redirect,
  input wire logic mgmt_rx_err,
  input wire logic mgmt_fifo_full,
  input wire logic mgmt_tx_done
);
  import ethst_pkg::*;

  typedef struct packed {
    logic [`ETHST_NUM_CNT32-1:0][31:0] cnt;
    logic [63:0] rx_oct;
    logic [63:0] tx_oct;
    logic [31:0] rx_hi_snap;
    logic [31:0] tx_hi_snap;
    logic [63:0] rd_val;
    ethst_reg_id_type rd_id;
    logic [31:0] prdata;
    logic pslverr;
  } ethst_state_type;

  ethst_state_type st_reg;
  ethst_state_type st_next;
  ethst_rx_ev_type rx_ev;
  logic setup;
  logic commit;
  logic tx_good;
  logic [`ETHST_NUM_CNT32-1:0] ev;
  ethst_reg_id_type dec_id;

  function automatic ethst_reg_id_type decode(input logic [`ETHST_ADDR_W-1:0] a);
    case (a)
      `ETHST_OFF_BCAST_RX: decode = ETHST_ID_BCAST;
      `ETHST_OFF_MCAST_RX: decode = ETHST_ID_MCAST;
      `ETHST_OFF_GOOD_TX_FRAME: decode = ETHST_ID_GTX;
      `ETHST_OFF_GOOD_RX_OCT_LO: decode = ETHST_ID_RXLO;
      `ETHST_OFF_GOOD_RX_OCT_HI: decode = ETHST_ID_RXHI;
      `ETHST_OFF_GOOD_TX_OCT_LO: decode = ETHST_ID_TXLO;
      `ETHST_OFF_GOOD_TX_OCT_HI: decode = ETHST_ID_TXHI;
      `ETHST_OFF_NO_HOST_BUF: decode = ETHST_ID_NOBUF;
      `ETHST_OFF_SHORT_GOOD_CRC: decode = ETHST_ID_SGOOD;
      `ETHST_OFF_SHORT_BAD_CRC: decode = ETHST_ID_SBAD;
      `ETHST_OFF_LONG_FRAME: decode = ETHST_ID_LONG;
      `ETHST_OFF_LONG_BAD_CRC: decode = ETHST_ID_LBAD;
      `ETHST_OFF_MGMT_RX: decode = ETHST_ID_MRX;
      `ETHST_OFF_MGMT_DROP: decode = ETHST_ID_MDROP;
      `ETHST_OFF_MGMT_TX: decode = ETHST_ID_MTX;
      default: decode = ETHST_ID_NONE;
    endcase
  endfunction : decode

  // take away what the read returned, add the new event, clamp at the limit
  function automatic logic [63:0] sat_upd(input logic [63:0] cur, input logic [63:0] rd,
                                          input logic [63:0] add, input logic [63:0] lim);
    logic [64:0] s;
    s = {1'b0, cur - rd} + {1'b0, add};
    if (s > {1'b0, lim}) begin
      sat_upd = lim;
    end else begin
      sat_upd = s[63:0];
    end
  endfunction : sat_upd

  function automatic logic [63:0] cnt_lim(input int idx);
    if (idx == int'(ETHST_ID_MDROP) || idx == int'(ETHST_ID_MTX)) begin
      cnt_lim = `ETHST_LIM_16;
    end else begin
      cnt_lim = `ETHST_LIM_32;
    end
  endfunction : cnt_lim

  ethst_rx_class u_rx_class (
    .sys_clk(sys_clk),
    .srst(srst),
    .rx_frame_done(rx_frame_done),
    .rx_frame_len(rx_frame_len),
    .rx_crc_ok(rx_crc_ok),
    .rx_addr_pass(rx_addr_pass),
    .rx_is_bcast(rx_is_bcast),
    .rx_is_mcast(rx_is_mcast),
    .rx_is_flow_ctrl(rx_is_flow_ctrl),
    .rx_fifo_missed(rx_fifo_missed),
    .rx_desc_empty(rx_desc_empty),
    .rx_enable(rx_enable),
    .long_frame_enable(long_frame_enable),
    .rx_ev(rx_ev)
  );

  // no secure flag is looked at: clear and secured frames count the same
  assign tx_good = tx_frame_done & tx_ok & ~tx_is_flow_ctrl & tx_enable &
    (tx_frame_len >= `ETHST_MIN_FRAME); // RULE_03 RULE_04 RULE_09

  always_comb begin
    ev = '0;
    ev[ETHST_ID_BCAST] = rx_ev.bcast;
    ev[ETHST_ID_MCAST] = rx_ev.mcast;
    ev[ETHST_ID_GTX] = tx_good;
    ev[ETHST_ID_NOBUF] = rx_ev.nobuf;
    ev[ETHST_ID_SGOOD] = rx_ev.short_good;
    ev[ETHST_ID_SBAD] = rx_ev.short_bad;
    ev[ETHST_ID_LONG] = rx_ev.long_any;
    ev[ETHST_ID_LBAD] = rx_ev.long_bad;
    ev[ETHST_ID_MRX] = mgmt_rx_done & (mgmt_filter_pass | mgmt_cb_redirect) &
      (~mgmt_rx_err | mgmt_fifo_full); // RULE_16
    ev[ETHST_ID_MDROP] = mgmt_rx_done & mgmt_filter_pass & mgmt_fifo_full; // RULE_17
    ev[ETHST_ID_MTX] = mgmt_tx_done; // RULE_18
  end

  assign setup = psel & ~penable;
  // zero wait states: data was latched in the setup cycle
  assign commit = psel & penable & ~pwrite;
  assign dec_id = decode(paddr);

  always_comb begin
    st_next = st_reg;
    // clearing subtracts the value that was returned, so counts that landed
    // between setup and access survive, and so does one in the clear cycle
    for (int i = 0; i < `ETHST_NUM_CNT32; i++) begin
      st_next.cnt[i] = 32'(sat_upd({32'h0, st_reg.cnt[i]},
        (commit && int'(st_reg.rd_id) == i) ? st_reg.rd_val : 64'h0,
        {63'h0, ev[i]}, cnt_lim(i))); // RULE_19 RULE_22 RULE_20
    end
    // low-half read clears the whole pair; high-half read clears nothing
    st_next.rx_oct = sat_upd(st_reg.rx_oct,
      (commit && st_reg.rd_id == ETHST_ID_RXLO) ? st_reg.rd_val : 64'h0,
      rx_ev.oct_vld ? {48'h0, rx_ev.oct_len} : 64'h0, `ETHST_LIM_64); // RULE_05 RULE_21
    st_next.tx_oct = sat_upd(st_reg.tx_oct,
      (commit && st_reg.rd_id == ETHST_ID_TXLO) ? st_reg.rd_val : 64'h0,
      tx_good ? {48'h0, tx_frame_len} : 64'h0, `ETHST_LIM_64); // RULE_08 RULE_09
    if (setup) begin
      st_next.rd_id = pwrite ? ETHST_ID_NONE : dec_id;
      st_next.pslverr = (dec_id == ETHST_ID_NONE);
      st_next.rd_val = 64'h0;
      st_next.prdata = 32'h0;
      if (!pwrite) begin
        case (dec_id)
          ETHST_ID_RXLO: begin
            st_next.rd_val = st_reg.rx_oct;
            st_next.rx_hi_snap = st_reg.rx_oct[63:32]; // RULE_06
            st_next.prdata = st_reg.rx_oct[31:0];
          end
          ETHST_ID_TXLO: begin
            st_next.rd_val = st_reg.tx_oct;
            st_next.tx_hi_snap = st_reg.tx_oct[63:32]; // RULE_06
            st_next.prdata = st_reg.tx_oct[31:0];
          end
          ETHST_ID_RXHI: begin
            st_next.prdata = st_reg.rx_hi_snap; // RULE_06 RULE_21
          end
          ETHST_ID_TXHI: begin
            st_next.prdata = st_reg.tx_hi_snap; // RULE_21
          end
          ETHST_ID_NONE: begin
            st_next.prdata = 32'h0;
          end
          default: begin
            st_next.rd_val = {32'h0, st_reg.cnt[dec_id]};
            st_next.prdata = st_reg.cnt[dec_id]; // RULE_17 RULE_18
          end
        endcase
      end
    end else if (commit) begin
      // a read clears once only, even if the bus lingers
      st_next.rd_id = ETHST_ID_NONE;
    end
    if (srst) begin
      st_next = '0;
      st_next.rd_id = ETHST_ID_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  // no back-pressure: read data were fetched in the setup cycle
  assign pready = psel & penable;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  logic rd_bcast;
  logic rd_rxlo;
  logic rd_txlo;
  logic rd_rxhi;
  logic [31:0] bcast_cnt;
  assign rd_bcast = commit && st_reg.rd_id == ETHST_ID_BCAST;
  assign rd_rxlo = commit && st_reg.rd_id == ETHST_ID_RXLO;
  assign rd_txlo = commit && st_reg.rd_id == ETHST_ID_TXLO;
  assign rd_rxhi = commit && st_reg.rd_id == ETHST_ID_RXHI;
  assign bcast_cnt = st_reg.cnt[ETHST_ID_BCAST];
  logic rd_gtx;
  logic rd_mtx;
  logic [31:0] mtx_cnt;
  assign rd_gtx = commit && st_reg.rd_id == ETHST_ID_GTX;
  assign rd_mtx = commit && st_reg.rd_id == ETHST_ID_MTX;
  assign mtx_cnt = st_reg.cnt[ETHST_ID_MTX];

  AST_BCAST_CLEAR: assert property (rd_bcast && !rx_ev.bcast |=> // RULE_19
    bcast_cnt == $past(bcast_cnt) - $past(st_reg.rd_val[31:0]))
    else $error("broadcast count not cleared by read");
  AST_BCAST_SAT: assert property (bcast_cnt == 32'hFFFF_FFFF && !rd_bcast |=> // RULE_19
    bcast_cnt == 32'hFFFF_FFFF)
    else $error("broadcast count wrapped");
  AST_CLEAR_KEEPS_EVENT: assert property (rd_bcast && rx_ev.bcast && // RULE_22
    bcast_cnt == st_reg.rd_val[31:0] |=> bcast_cnt == 32'h0000_0001)
    else $error("event lost in clearing cycle");
  AST_TX_OCT_SAT: assert property (st_reg.tx_oct == `ETHST_LIM_64 && !rd_txlo |=> // RULE_08
    st_reg.tx_oct == `ETHST_LIM_64)
    else $error("tx octet count left saturation");
  AST_RX_SNAP: assert property (setup && !pwrite && dec_id == ETHST_ID_RXLO |=> // RULE_06
    st_reg.rx_hi_snap == $past(st_reg.rx_oct[63:32]) ##1 st_reg.rx_oct[63:32] == 32'h0
    || $past(rx_ev.oct_vld) || $past(rx_ev.oct_vld, 2))
    else $error("upper octet half not captured");
  AST_HI_READ: assert property (rd_rxhi && !rx_ev.oct_vld |=> // RULE_21
    st_reg.rx_oct == $past(st_reg.rx_oct))
    else $error("high read disturbed running count");
  AST_TX_SHORT: assert property (tx_frame_done && tx_frame_len < `ETHST_MIN_FRAME && // RULE_03
    !(commit && st_reg.rd_id == ETHST_ID_GTX) |=>
    st_reg.cnt[ETHST_ID_GTX] == $past(st_reg.cnt[ETHST_ID_GTX]))
    else $error("short tx frame counted");
  AST_RX_DISABLED: assert property (rx_frame_done && !rx_enable |=> // RULE_15
    !(rx_ev.nobuf || rx_ev.short_good || rx_ev.short_bad || rx_ev.long_any))
    else $error("error counter event while rx disabled");
  AST_OVERSIZE_STD: assert property (rx_frame_done && rx_enable && rx_addr_pass && // RULE_13
    !long_frame_enable && rx_frame_len == 16'h05F3 |=> rx_ev.long_any)
    else $error("1523 byte frame not oversize");
  AST_OVERSIZE_LONG: assert property (rx_frame_done && long_frame_enable && // RULE_14
    rx_frame_len == `ETHST_MAX_LONG_FRAME |=> !rx_ev.long_any && !rx_ev.long_bad)
    else $error("16384 byte frame counted oversize");
  AST_EVENT_LATENCY: assert property (rx_frame_done && rx_enable && rx_addr_pass && // RULE_20
    rx_crc_ok && !rx_fifo_missed && rx_is_bcast && bcast_cnt == 32'h0 && !psel
    ##1 !psel |=> bcast_cnt != 32'h0)
    else $error("broadcast event not counted in time");
  AST_MDROP_UPPER: assert property (setup && !pwrite && dec_id == ETHST_ID_MDROP |=> // RULE_17
    prdata[31:16] == 16'h0000)
    else $error("drop count upper bits not zero");
  AST_UNMAPPED: assert property (setup && dec_id == ETHST_ID_NONE |=> pslverr)
    else $error("unmapped address not flagged");

  // the 16-bit counters are the only ones a short run can fill
  AST_MTX_SAT: assert property (mtx_cnt == 32'h0000_FFFF && !rd_mtx |=> // RULE_19
    mtx_cnt == 32'h0000_FFFF)
    else $error("mgmt tx count wrapped");
  AST_MDROP_SAT: assert property (st_reg.cnt[ETHST_ID_MDROP] <= 32'h0000_FFFF) // RULE_17
    else $error("drop count above 16 bits");
  AST_MTX_UPPER: assert property (setup && !pwrite && dec_id == ETHST_ID_MTX |=> // RULE_18
    prdata[31:16] == 16'h0000)
    else $error("mgmt tx upper bits not zero");
  AST_TX_DISABLED: assert property (tx_frame_done && !tx_enable && !rd_gtx |=> // RULE_03
    st_reg.cnt[ETHST_ID_GTX] == $past(st_reg.cnt[ETHST_ID_GTX]))
    else $error("tx frame counted while disabled");
  AST_TX_FLOW_OCT: assert property (tx_frame_done && tx_is_flow_ctrl && !rd_txlo |=> // RULE_09
    st_reg.tx_oct == $past(st_reg.tx_oct))
    else $error("flow control tx octets counted");
  AST_RX_FLOW: assert property (rx_frame_done && rx_is_flow_ctrl |=> // RULE_02 RULE_10
    !rx_ev.mcast && !rx_ev.nobuf && !rx_ev.oct_vld)
    else $error("flow control rx frame counted");
  AST_RX_MISSED: assert property (rx_frame_done && rx_fifo_missed |=> // RULE_01
    !rx_ev.bcast && !rx_ev.mcast && !rx_ev.oct_vld)
    else $error("missed frame counted as good");
  // crc alone decides which short counter moves
  AST_SHORT_SPLIT: assert property (rx_frame_done && rx_enable && // RULE_11 RULE_12
    rx_addr_pass && rx_frame_len < `ETHST_MIN_FRAME |=>
    rx_ev.short_good == $past(rx_crc_ok) && rx_ev.short_bad == !$past(rx_crc_ok))
    else $error("short frame crc split wrong");
  AST_OVERSIZE_EDGE: assert property (rx_frame_done && rx_enable && rx_addr_pass && // RULE_13
    !long_frame_enable && rx_frame_len == 16'h05F2 |=> !rx_ev.long_any)
    else $error("1522 byte frame oversize");
  AST_JABBER: assert property (rx_ev.long_bad |-> rx_ev.long_any) // RULE_14
    else $error("jabber without oversize");
  AST_MRX_ERR: assert property (mgmt_rx_done && mgmt_rx_err && !mgmt_fifo_full && // RULE_16
    !(commit && st_reg.rd_id == ETHST_ID_MRX) |=>
    st_reg.cnt[ETHST_ID_MRX] == $past(st_reg.cnt[ETHST_ID_MRX]))
    else $error("errored mgmt frame counted");
  AST_MAPPED: assert property (setup && dec_id != ETHST_ID_NONE |=> !pslverr)
    else $error("mapped address flagged");

  CVR_BCAST_READ: cover property (rd_bcast && bcast_cnt != 32'h0);
  CVR_LO_HI: cover property (rd_rxlo ##[2:20] rd_rxhi);
  CVR_TX_SAT: cover property (st_reg.tx_oct == `ETHST_LIM_64);
  CVR_LONG_BAD: cover property (rx_ev.long_bad);
  CVR_MTX_SAT: cover property (mtx_cnt == 32'h0000_FFFF);

endmodule : ethst_counters

/* File: dv/tb_ethst_counters.sv */
// self-checking testbench of the ethernet statistics counter bank
`timescale 1ns/10ps
`include "ethst_consts.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module tb_ethst_counters;
  import ethst_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr;
  logic rx_frame_done = 1'b0, rx_crc_ok = 1'b0, rx_addr_pass = 1'b0, rx_is_bcast = 1'b0;
  logic rx_is_mcast = 1'b0, rx_is_flow_ctrl = 1'b0, rx_fifo_missed = 1'b0;
  logic rx_desc_empty = 1'b0, rx_enable = 1'b1, long_frame_enable = 1'b0;
  logic [15:0] rx_frame_len = 16'h0000, tx_frame_len = 16'h0000;
  logic tx_frame_done = 1'b0, tx_ok = 1'b0, tx_is_flow_ctrl = 1'b0, tx_enable = 1'b1;
  logic mgmt_rx_done = 1'b0, mgmt_filter_pass = 1'b0, mgmt_cb_redirect = 1'b0;
  logic mgmt_rx_err = 1'b0, mgmt_fifo_full = 1'b0, mgmt_tx_done = 1'b0;
  int num_errors = 0, checked = 0, cycles = 0;
  logic [31:0] rdv;
  logic rde;
  localparam logic [15:0] ADDRS [15] = '{`ETHST_OFF_BCAST_RX, `ETHST_OFF_MCAST_RX,
    `ETHST_OFF_GOOD_TX_FRAME, `ETHST_OFF_GOOD_RX_OCT_LO, `ETHST_OFF_GOOD_RX_OCT_HI,
    `ETHST_OFF_GOOD_TX_OCT_LO, `ETHST_OFF_GOOD_TX_OCT_HI, `ETHST_OFF_NO_HOST_BUF,
    `ETHST_OFF_SHORT_GOOD_CRC, `ETHST_OFF_SHORT_BAD_CRC, `ETHST_OFF_LONG_FRAME,
    `ETHST_OFF_LONG_BAD_CRC, `ETHST_OFF_MGMT_RX, `ETHST_OFF_MGMT_DROP, `ETHST_OFF_MGMT_TX};

  ethst_counters dut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_frame_done(rx_frame_done), .rx_frame_len(rx_frame_len),
    .rx_crc_ok(rx_crc_ok), .rx_addr_pass(rx_addr_pass), .rx_is_bcast(rx_is_bcast),
    .rx_is_mcast(rx_is_mcast), .rx_is_flow_ctrl(rx_is_flow_ctrl),
    .rx_fifo_missed(rx_fifo_missed), .rx_desc_empty(rx_desc_empty), .rx_enable(rx_enable),
    .long_frame_enable(long_frame_enable), .tx_frame_done(tx_frame_done),
    .tx_frame_len(tx_frame_len), .tx_ok(tx_ok), .tx_is_flow_ctrl(tx_is_flow_ctrl),
    .tx_enable(tx_enable), .mgmt_rx_done(mgmt_rx_done), .mgmt_filter_pass(mgmt_filter_pass),
    .mgmt_cb_redirect(mgmt_cb_redirect), .mgmt_rx_err(mgmt_rx_err),
    .mgmt_fifo_full(mgmt_fifo_full), .mgmt_tx_done(mgmt_tx_done));

  always #20 sys_clk = ~sys_clk;

  task automatic print_verdict;
    $display("counts: checked %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // hang guard: snapshot test alone needs some 66k cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [15:0] a, output logic [31:0] d,
                     output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= 32'hA5A5_5A5A;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk_rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, d, e);
    `CHK(d, exp)
    `CHK(e, 1'b0)
  endtask : chk_rd

  task automatic rx(input logic [15:0] len, input logic crc, ap, bc, mc, fc, ms, de);
    @(posedge sys_clk);
    rx_frame_done <= 1'b1;
    rx_frame_len <= len;
    rx_crc_ok <= crc;
    rx_addr_pass <= ap;
    rx_is_bcast <= bc;
    rx_is_mcast <= mc;
    rx_is_flow_ctrl <= fc;
    rx_fifo_missed <= ms;
    rx_desc_empty <= de;
    @(posedge sys_clk);
    rx_frame_done <= 1'b0;
    // classifier adds one stage before the counter
    repeat (3) @(posedge sys_clk);
  endtask : rx

  task automatic tx(input logic [15:0] len, input logic ok, fc);
    @(posedge sys_clk);
    tx_frame_done <= 1'b1;
    tx_frame_len <= len;
    tx_ok <= ok;
    tx_is_flow_ctrl <= fc;
    @(posedge sys_clk);
    tx_frame_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : tx

  task automatic mg(input logic fp, cb, er, ff);
    @(posedge sys_clk);
    mgmt_rx_done <= 1'b1;
    mgmt_filter_pass <= fp;
    mgmt_cb_redirect <= cb;
    mgmt_rx_err <= er;
    mgmt_fifo_full <= ff;
    @(posedge sys_clk);
    mgmt_rx_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : mg

  task automatic test_reset_map;
    foreach (ADDRS[i]) chk_rd(ADDRS[i], `ETHST_RESET_VAL);
    apb(1'b0, 16'h4084, rdv, rde);
    `CHK({rde, rdv}, {1'b1, 32'h0000_0000})
    apb(1'b1, 16'h4098, rdv, rde);
    `CHK(rde, 1'b1)
    apb(1'b1, `ETHST_OFF_BCAST_RX, rdv, rde);
    `CHK(rde, 1'b0)
    chk_rd(`ETHST_OFF_BCAST_RX, 32'h0000_0000);
    $display("test reset_map done");
  endtask : test_reset_map

  task automatic test_rx_good;
    rx(16'h0064, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h00C8, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    rx(16'h012C, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    rx(16'h0190, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    rx(16'h01F4, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h0258, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_rd(`ETHST_OFF_BCAST_RX, 32'h0000_0001);
    chk_rd(`ETHST_OFF_MCAST_RX, 32'h0000_0001);
    chk_rd(`ETHST_OFF_GOOD_RX_OCT_LO, 32'h0000_012C);
    chk_rd(`ETHST_OFF_GOOD_RX_OCT_HI, 32'h0000_0000);
    chk_rd(`ETHST_OFF_BCAST_RX, 32'h0000_0000);
    $display("test rx_good done");
  endtask : test_rx_good

  task automatic test_rx_errors;
    rx(16'h003F, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h0040, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h003F, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h003F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h05F2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h05F3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h05F3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h0064, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rx(16'h0064, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    long_frame_enable <= 1'b1;
    rx(16'h05F3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h4000, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h4001, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx_enable <= 1'b0;
    rx(16'h003F, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rx(16'h003F, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(16'h4001, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rx_enable <= 1'b1;
    long_frame_enable <= 1'b0;
    chk_rd(`ETHST_OFF_SHORT_GOOD_CRC, 32'h0000_0001);
    chk_rd(`ETHST_OFF_SHORT_BAD_CRC, 32'h0000_0001);
    chk_rd(`ETHST_OFF_LONG_FRAME, 32'h0000_0003);
    chk_rd(`ETHST_OFF_LONG_BAD_CRC, 32'h0000_0002);
    chk_rd(`ETHST_OFF_NO_HOST_BUF, 32'h0000_0001);
    $display("test rx_errors done");
  endtask : test_rx_errors

  task automatic test_tx_mgmt;
    tx(16'h0040, 1'b1, 1'b0);
    tx(16'h003F, 1'b1, 1'b0);
    tx(16'h0080, 1'b1, 1'b1);
    tx(16'h0080, 1'b0, 1'b0);
    tx_enable <= 1'b0;
    tx(16'h0080, 1'b1, 1'b0);
    tx_enable <= 1'b1;
    chk_rd(`ETHST_OFF_GOOD_TX_FRAME, 32'h0000_0001);
    chk_rd(`ETHST_OFF_GOOD_TX_OCT_LO, 32'h0000_0040);
    mg(1'b1, 1'b0, 1'b0, 1'b0);
    mg(1'b0, 1'b1, 1'b0, 1'b0);
    mg(1'b1, 1'b0, 1'b1, 1'b0);
    mg(1'b1, 1'b0, 1'b1, 1'b1);
    mg(1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge sys_clk);
    mgmt_tx_done <= 1'b1;
    @(posedge sys_clk);
    mgmt_tx_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_rd(`ETHST_OFF_MGMT_RX, 32'h0000_0003);
    chk_rd(`ETHST_OFF_MGMT_DROP, 32'h0000_0001);
    chk_rd(`ETHST_OFF_MGMT_TX, 32'h0000_0001);
    $display("test tx_mgmt done");
  endtask : test_tx_mgmt

  task automatic test_snapshot;
    // 65538 maximal frames carry the octet count past 2^32
    @(posedge sys_clk);
    tx_frame_done <= 1'b1;
    tx_frame_len <= 16'hFFFF;
    tx_ok <= 1'b1;
    tx_is_flow_ctrl <= 1'b0;
    // management counters ride along; the drop and tx counts run into their 16-bit ceiling
    mgmt_rx_done <= 1'b1;
    mgmt_filter_pass <= 1'b1;
    mgmt_fifo_full <= 1'b1;
    mgmt_tx_done <= 1'b1;
    repeat (65538) @(posedge sys_clk);
    tx_frame_done <= 1'b0;
    mgmt_rx_done <= 1'b0;
    mgmt_tx_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_rd(`ETHST_OFF_MGMT_RX, 32'h0001_0002);
    chk_rd(`ETHST_OFF_MGMT_DROP, 32'h0000_FFFF);
    chk_rd(`ETHST_OFF_MGMT_TX, 32'h0000_FFFF);
    chk_rd(`ETHST_OFF_GOOD_TX_OCT_LO, 32'h0000_FFFE);
    tx(16'h0040, 1'b1, 1'b0);
    chk_rd(`ETHST_OFF_GOOD_TX_OCT_HI, 32'h0000_0001);
    chk_rd(`ETHST_OFF_GOOD_TX_OCT_HI, 32'h0000_0001);
    chk_rd(`ETHST_OFF_GOOD_TX_OCT_LO, 32'h0000_0040);
    chk_rd(`ETHST_OFF_GOOD_TX_OCT_HI, 32'h0000_0000);
    // one more frame lands on the clearing access edge
    fork
      chk_rd(`ETHST_OFF_GOOD_TX_FRAME, 32'h0001_0003);
      begin
        repeat (2) @(posedge sys_clk);
        tx_frame_done <= 1'b1;
        tx_frame_len <= 16'h0040;
        @(posedge sys_clk);
        tx_frame_done <= 1'b0;
      end
    join
    chk_rd(`ETHST_OFF_GOOD_TX_FRAME, 32'h0000_0001);
    $display("test snapshot done");
  endtask : test_snapshot

  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    test_reset_map();
    test_rx_good();
    test_rx_errors();
    test_tx_mgmt();
    test_snapshot();
    print_verdict();
  end
endmodule : tb_ethst_counters
